/* hdl/sbcp_packetizer.sv */
// Capture packetizer: bus traffic into transaction or physical-layer packet bodies
//
// Behaviour
// RULE1: General-purpose channel word carries body type code 010 in bits 31-29.
// RULE2: Transaction-format per-transaction header is only an eight-byte time stamp.
// RULE3: General-purpose body carries whole bus packets of any kind, mixed freely.
// RULE4: Channel word followed by at least one transaction; tally equals transactions.
// RULE5: Each transaction follows its time stamp header, recorded complete right after.
// RULE6: Specification revision in use is declared for the setup record.
// RULE7: Every captured packet's transaction code is a 4-bit format field.
// RULE8: Physical-layer packet holds a bounded number of transfers within size limits.
// RULE9: Physical channel word: reserved upper half, unit count in low 16 bits.
// RULE10: Transfer header is two time stamp words, then ID word, then data.
// RULE11: Relative time is 48-bit counter at first byte, second word low half zero.
// RULE12: Flag bit 6 selects absolute time, format given by flag bits 2 and 3.
// RULE13: ID word holds status, speed, overrun code, drop flag, reserved, length.
// RULE14: Speed field carries the transmission speed code; other values reserved.
// RULE15: Overrun code 00 normal, 01 overlong start, 10 ended ok, 11 still overlong.
// RULE16: Overrun episode is 01, zero or more 11, then 10; else 00.
// RULE17: Drop flag set when messages were lost before this transfer.
// RULE18: Length capped at 4120 asynchronous and 32780 isochronous bytes.
// RULE19: Lengths not a multiple of four get one to three zero fill bytes.
// RULE20: Zero length means no data follows the ID word.
// RULE21: Transfer data is exactly one bus transmission including header and CRC.
// RULE22: Length counts exactly the encapsulated bytes, never the fill.
// RULE23: Reserved bits of channel and ID words are written as zero.
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
module sbcp_packetizer
#(
  parameter logic [7:0] SPEC_REV = `SBCP_SPEC_REV,
  parameter logic [15:0] BODY_LIMIT = `SBCP_BODY_LIMIT
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire sbcp_pkg::sbcp_cap_t cap,
  output logic capReady,
  input wire logic capDrop,
  input wire logic [47:0] relTime,
  input wire logic [63:0] absTime,
  output sbcp_pkg::sbcp_wr_t store,
  output logic [7:0] packetFlags,
  output logic [7:0] specRevision,
  output logic packetDone
);
  import sbcp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DATA = 3'b001,
    S_TAIL = 3'b010,
    S_HT0 = 3'b011,
    S_HT1 = 3'b100,
    S_HID = 3'b101,
    S_DONE = 3'b110,
    S_CSDW = 3'b111
  } sbcp_state_t;

  sbcp_state_t state_reg, state_next;
  logic en_reg, fmt_reg, pktFmt_reg, closeReq_reg;
  logic [15:0] count_reg, byteCnt_reg, len_reg, lastWords_reg;
  logic [`SBCP_AW-1:0] wrPtr_reg, dataPtr_reg, base_reg;
  logic [63:0] stamp_reg;
  logic [7:0] status_reg;
  logic [3:0] speed_reg, tcode_reg;
  logic exceeded_reg, prevOvf_reg, dropPend_reg;
  logic accept, keep, closeWant, wbReq, pkValid, pkWordValid;
  logic [15:0] maxLen, hdrWords;
  logic [31:0] pkWord;
  sbcp_id_t idWord;
  sbcp_cw0_t cw0;
  sbcp_cw1_t cw1;

  assign accept = cap.valid && capReady;
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hdrWords = pktFmt_reg ? `SBCP_HDR_FMT1 : `SBCP_HDR_FMT0;
  // Stream code is the long limit; assume it until the code byte is seen
  assign maxLen = (tcode_reg == `SBCP_TCODE_STREAM) ? `SBCP_MAX_ISO : `SBCP_MAX_ASYNC; // RULE18
  // First byte of a transfer is always kept; counters still hold the previous transfer then
  assign keep = !cap.empty && (state_reg == S_IDLE || byteCnt_reg < maxLen);
  // Transaction bodies may not close empty; count field bounds both formats
  assign closeWant = ((closeReq_reg || wrPtr_reg >= BODY_LIMIT) && (pktFmt_reg || count_reg != 16'h0000))
    || count_reg == `SBCP_CNT_MAX; // RULE4 RULE8

  // Assembled header and channel words; reserved fields fixed at zero
  always_comb
  begin
    idWord.status = status_reg;
    idWord.speed = speed_reg; // RULE14
    idWord.overrun = sbcp_ovr_t'({prevOvf_reg, exceeded_reg}); // RULE15 RULE16
    idWord.drop = dropPend_reg; // RULE17
    idWord.rsv = 1'b0; // RULE23
    idWord.len = len_reg; // RULE13 RULE20 RULE22
    cw0.bodyType = `SBCP_BT_GP; // RULE1
    cw0.sync = 4'h0;
    cw0.rsv = 9'h000;
    cw0.tally = count_reg; // RULE4
    cw1.rsv = 16'h0000; // RULE9 RULE23
    cw1.units = count_reg;
  end

  // Sequencer: data, then header words written back into reserved slots
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (accept)
          state_next = cap.last ? S_TAIL : S_DATA;
        else if (closeWant)
          state_next = S_CSDW;
      S_DATA:
        if (accept && cap.last)
          state_next = S_TAIL;
      S_TAIL:
        state_next = S_HT0;
      S_HT0:
        state_next = S_HT1;
      S_HT1:
        state_next = pktFmt_reg ? S_HID : S_DONE; // RULE2 RULE10
      S_HID:
        state_next = S_DONE;
      S_DONE:
        state_next = S_IDLE;
      S_CSDW:
        state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // Ready only while bytes can be taken; header writes stall the source
  always_ff @(posedge core_clk)
  begin
    if (reset)
      capReady <= 1'b0;
    else
      capReady <= en_reg && (state_next == S_DATA || (state_next == S_IDLE && !closeWant));
  end

  // Per-transfer capture: stamp, status, speed, code and length
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stamp_reg <= 64'h0000000000000000;
      status_reg <= 8'h00;
      speed_reg <= 4'h0;
      tcode_reg <= `SBCP_TCODE_STREAM;
      byteCnt_reg <= 16'h0000;
      len_reg <= 16'h0000;
      exceeded_reg <= 1'b0;
    end
    else if (accept)
    begin
      if (state_reg == S_IDLE)
      begin
        if (packetFlags[`SBCP_FLG_ABS])
          stamp_reg <= absTime; // RULE12
        else if (pktFmt_reg)
          stamp_reg <= {relTime[47:32], 16'h0000, relTime[31:0]}; // RULE11
        else
          stamp_reg <= {16'h0000, relTime[47:32], relTime[31:0]}; // RULE2
        status_reg <= cap.status;
        speed_reg <= cap.speed; // RULE14
        tcode_reg <= `SBCP_TCODE_STREAM;
        byteCnt_reg <= cap.empty ? 16'h0000 : 16'h0001;
        len_reg <= cap.empty ? 16'h0000 : 16'h0001; // RULE20
        exceeded_reg <= 1'b0;
      end
      else
      begin
        if (byteCnt_reg == `SBCP_TCODE_BYTE)
          tcode_reg <= cap.data[7:4]; // RULE7
        if (byteCnt_reg != `SBCP_CNT_MAX)
          byteCnt_reg <= byteCnt_reg + 16'h0001;
        if (keep)
          len_reg <= len_reg + 16'h0001; // RULE22
        else
          exceeded_reg <= 1'b1; // RULE15
      end
    end
  end

  // Bytes past the limit are dropped but still end the transfer
  assign pkValid = accept && keep; // RULE3 RULE21

  sbcp_word_packer u_packer
  (
    .core_clk(core_clk),
    .reset(reset),
    .inValid(pkValid),
    .inByte(cap.data),
    .inFlush(accept && cap.last),
    .wordValid(pkWordValid),
    .wordData(pkWord)
  );

  // Store writes: data as it packs, headers after the last byte
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      store <= '0;
      dataPtr_reg <= `SBCP_PTR_FIRST;
      base_reg <= `SBCP_PTR_FIRST;
    end
    else
    begin
      store.wr <= 1'b0;
      if (accept && state_reg == S_IDLE)
      begin
        base_reg <= wrPtr_reg;
        dataPtr_reg <= wrPtr_reg + hdrWords; // RULE5 RULE10
      end
      else if (pkWordValid)
      begin
        store <= '{wr: 1'b1, addr: dataPtr_reg, data: pkWord};
        dataPtr_reg <= dataPtr_reg + `SBCP_PTR_FIRST;
      end
      case (state_reg)
        S_HT0:
          store <= '{wr: 1'b1, addr: base_reg, data: stamp_reg[31:0]};
        S_HT1:
          store <= '{wr: 1'b1, addr: base_reg + `SBCP_PTR_FIRST, data: stamp_reg[63:32]};
        S_HID:
          store <= '{wr: 1'b1, addr: base_reg + `SBCP_HDR_FMT0, data: idWord}; // RULE13
        S_CSDW:
          store <= '{wr: 1'b1, addr: '0, data: pktFmt_reg ? 32'(cw1) : 32'(cw0)}; // RULE9
        default:
          ;
      endcase
    end
  end

  // Transfer bookkeeping and packet close
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wrPtr_reg <= `SBCP_PTR_FIRST;
      count_reg <= 16'h0000;
      prevOvf_reg <= 1'b0;
      lastWords_reg <= 16'h0000;
      packetDone <= 1'b0;
      pktFmt_reg <= 1'b0;
    end
    else
    begin
      packetDone <= 1'b0;
      if (state_reg == S_IDLE && count_reg == 16'h0000)
        pktFmt_reg <= fmt_reg;
      if (state_reg == S_DONE)
      begin
        wrPtr_reg <= dataPtr_reg;
        count_reg <= count_reg + 16'h0001; // RULE4 RULE8
        prevOvf_reg <= exceeded_reg; // RULE16
      end
      if (state_reg == S_CSDW)
      begin
        lastWords_reg <= 16'(wrPtr_reg);
        wrPtr_reg <= `SBCP_PTR_FIRST;
        count_reg <= 16'h0000;
        packetDone <= 1'b1;
      end
    end
  end

  // Drop notice held until written; a new drop beats the clear
  always_ff @(posedge core_clk)
  begin
    if (reset)
      dropPend_reg <= 1'b0;
    else if (capDrop)
      dropPend_reg <= 1'b1; // RULE17
    else if (state_reg == S_DONE && pktFmt_reg)
      dropPend_reg <= 1'b0;
  end

  // Wishbone writes; close request set wins over its own clear
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      en_reg <= 1'b0;
      fmt_reg <= 1'b0;
      closeReq_reg <= 1'b0;
      packetFlags <= 8'h00;
      specRevision <= SPEC_REV;
    end
    else
    begin
      if (state_reg == S_CSDW)
        closeReq_reg <= 1'b0;
      if (wbReq && wb_we_i && wb_sel_i[0])
        case (wb_adr_i)
          `SBCP_OFF_CTRL:
          begin
            en_reg <= wb_dat_i[`SBCP_CTRL_EN];
            fmt_reg <= wb_dat_i[`SBCP_CTRL_FMT];
            if (wb_dat_i[`SBCP_CTRL_CLOSE])
              closeReq_reg <= 1'b1;
          end
          `SBCP_OFF_FLAGS:
            packetFlags <= wb_dat_i[7:0]; // RULE12
          `SBCP_OFF_SPECREV:
            specRevision <= wb_dat_i[7:0]; // RULE6
          default:
            ;
        endcase
    end
  end

  // Read data and ack; one wait cycle, unmapped reads return zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h00000000;
      if (wbReq && !wb_we_i)
        case (wb_adr_i)
          `SBCP_OFF_CTRL:
            wb_dat_o <= {29'h00000000, closeReq_reg, fmt_reg, en_reg};
          `SBCP_OFF_FLAGS:
            wb_dat_o <= {24'h000000, packetFlags};
          `SBCP_OFF_SPECREV:
            wb_dat_o <= {24'h000000, specRevision};
          `SBCP_OFF_STATUS:
            wb_dat_o <= {count_reg, tcode_reg, 1'b0, pktFmt_reg, prevOvf_reg, dropPend_reg, 5'h00, state_reg};
          `SBCP_OFF_WORDS:
            wb_dat_o <= {16'h0000, lastWords_reg};
          default:
            wb_dat_o <= 32'h00000000;
        endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_tail_fmt0;
    state_reg == S_TAIL && !pktFmt_reg ##1 state_reg == S_HT0 ##1 state_reg == S_HT1;
  endsequence

  AST_CW0_TYPE: assert property (state_reg == S_CSDW && !pktFmt_reg |=> store.data[31:29] == `SBCP_BT_GP) // RULE1
    else $error("body type code not general purpose");
  AST_HDR_TWO: assert property (s_tail_fmt0 |=> state_reg == S_DONE ##1 state_reg == S_IDLE) // RULE2
    else $error("transaction header is not two words");
  AST_NO_EMPTY: assert property (state_reg == S_CSDW && !pktFmt_reg |-> count_reg != 16'h0000) // RULE4
    else $error("transaction body closed without transactions");
  AST_REL_FILL: assert property (state_reg == S_HT1 && pktFmt_reg && !packetFlags[`SBCP_FLG_ABS]
    |=> store.wr && store.data[15:0] == 16'h0000) // RULE11
    else $error("relative stamp low half not zero");
  AST_ID_RSV: assert property (state_reg == S_HID |=> store.wr && store.data[16] == 1'b0) // RULE23
    else $error("reserved id bit set");
  AST_LEN_CAP: assert property (len_reg <= `SBCP_MAX_ISO) // RULE18
    else $error("length above isochronous limit");
  AST_OVR_SEQ: assert property (state_reg == S_HID |=> store.data[19] == $past(prevOvf_reg)) // RULE16
    else $error("overrun code ignores preceding overrun");
  AST_DROP: assert property (state_reg == S_HID && dropPend_reg |=> store.data[17]) // RULE17
    else $error("drop flag missing from id word");
  AST_CW1_RSV: assert property (state_reg == S_CSDW && pktFmt_reg |=> store.data[31:16] == 16'h0000) // RULE9
    else $error("physical channel word upper half not zero");
endmodule : sbcp_packetizer

/* hdl/sbcp_cfg.svh */
// Offsets, field positions, limits and reset values of the capture packetizer
`ifndef SBCP_CFG_SVH
`define SBCP_CFG_SVH
`define SBCP_AW 16
`define SBCP_OFF_CTRL 8'h00
`define SBCP_OFF_FLAGS 8'h04
`define SBCP_OFF_SPECREV 8'h08
`define SBCP_OFF_STATUS 8'h0C
`define SBCP_OFF_WORDS 8'h10
`define SBCP_CTRL_EN 0
`define SBCP_CTRL_FMT 1
`define SBCP_CTRL_CLOSE 2
`define SBCP_FLG_ABS 6
`define SBCP_BT_GP 3'h2
`define SBCP_MAX_ASYNC 16'h1018
`define SBCP_MAX_ISO 16'h800C
`define SBCP_TCODE_STREAM 4'hA
`define SBCP_TCODE_BYTE 16'h0003
`define SBCP_CNT_MAX 16'hFFFF
`define SBCP_HDR_FMT0 16'h0002
`define SBCP_HDR_FMT1 16'h0003
`define SBCP_PTR_FIRST 16'h0001
`define SBCP_SPEC_REV 8'h00
`define SBCP_BODY_LIMIT 16'hF000
`endif

/* hdl/sbcp_pkg.sv */
// Types shared by the capture packetizer files
package sbcp_pkg;
  `include "sbcp_cfg.svh"

  typedef enum logic [1:0] {
    OVR_NONE = 2'b00,
    OVR_START = 2'b01,
    OVR_END = 2'b10,
    OVR_MORE = 2'b11
  } sbcp_ovr_t;

  typedef enum logic [3:0] {
    SPD_S100A = 4'h0, SPD_S100B = 4'h1, SPD_S200A = 4'h2, SPD_S200B = 4'h3,
    SPD_S400A = 4'h4, SPD_S400B = 4'h5, SPD_S800B = 4'h7, SPD_S1600B = 4'h9,
    SPD_S3200B = 4'hA
  } sbcp_speed_t;

  // Captured bus byte with its per-transfer side information
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic empty;
    logic [7:0] status;
    logic [3:0] speed;
  } sbcp_cap_t;

  // One word write into the packet store
  typedef struct packed {
    logic wr;
    logic [`SBCP_AW-1:0] addr;
    logic [31:0] data;
  } sbcp_wr_t;

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] speed;
    sbcp_ovr_t overrun;
    logic drop;
    logic rsv;
    logic [15:0] len;
  } sbcp_id_t;

  typedef struct packed {
    logic [2:0] bodyType;
    logic [3:0] sync;
    logic [8:0] rsv;
    logic [15:0] tally;
  } sbcp_cw0_t;

  typedef struct packed {
    logic [15:0] rsv;
    logic [15:0] units;
  } sbcp_cw1_t;
endpackage : sbcp_pkg

/* hdl/sbcp_word_packer.sv */
// Packs bytes big-endian into 32-bit words with zero fill on flush
`timescale 1ns/100ps
module sbcp_word_packer
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic inValid,
  input wire logic [7:0] inByte,
  input wire logic inFlush,
  output logic wordValid,
  output logic [31:0] wordData
);
  import sbcp_pkg::*;

  logic [31:0] acc_reg;
  logic [1:0] idx_reg;
  logic [31:0] accNext;
  logic [2:0] cntNext;

  // Place the new byte below those already held
  always_comb
  begin
    accNext = acc_reg;
    if (inValid)
      accNext = acc_reg | ({inByte, 24'h000000} >> {idx_reg, 3'b000});
    cntNext = {1'b0, idx_reg} + {2'b00, inValid};
  end

  // Emit on a full word, or on flush; untouched lanes stay zero as fill
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      acc_reg <= 32'h00000000;
      idx_reg <= 2'h0;
      wordValid <= 1'b0;
      wordData <= 32'h00000000;
    end
    else
    begin
      wordValid <= 1'b0;
      if (cntNext == 3'h4 || (inFlush && cntNext != 3'h0))
      begin
        wordValid <= 1'b1; // RULE19
        wordData <= accNext;
        acc_reg <= 32'h00000000;
        idx_reg <= 2'h0;
      end
      else if (inValid || inFlush)
      begin
        acc_reg <= accNext;
        idx_reg <= cntNext[1:0];
      end
    end
  end

  AST_FILL_ZERO: assert property (@(posedge core_clk) disable iff (reset) // RULE19
    (inFlush && inValid && idx_reg == 2'h0) |=> (wordValid && wordData[23:0] == 24'h000000))
    else $error("fill bytes after a short tail are not zero");
endmodule : sbcp_word_packer

/* tb/sbcp_store_model.sv */
// Packet store model on the far side of the packetizer: keeps every body word written
`timescale 1ns/100ps
module sbcp_store_model
  import sbcp_pkg::*;
(
  input wire logic core_clk,
  input wire sbcp_pkg::sbcp_wr_t store
);
  logic [31:0] mem [0:65535];

  // Words land at the strobe edge; unwritten places stay unknown so stray reads never match
  always_ff @(posedge core_clk)
  begin
    if (store.wr)
      mem[store.addr] <= store.data;
  end
endmodule : sbcp_store_model

/* tb/sbcp_packetizer_bench.sv */
// Testbench for the capture packetizer: register access, both body formats, overrun runs
`timescale 1ns/100ps
module sbcp_packetizer_bench;
  import sbcp_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic capReady;
  logic capDrop = 1'b0;
  logic packetDone;
  sbcp_cap_t cap = '0;
  logic [47:0] relTime = 48'h0;
  logic [63:0] absTime = 64'h0;
  sbcp_wr_t store;
  logic [7:0] packetFlags;
  logic [7:0] specRevision;
  int err_count = 0;
  int samples_checked = 0;
  int doneCount = 0;
  logic [31:0] rd;
  logic [15:0] base = 16'h0001;
  logic absOn = 1'b0;
  localparam logic [3:0] SPD [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA};

  sbcp_packetizer dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cap(cap), .capReady(capReady), .capDrop(capDrop), .relTime(relTime),
    .absTime(absTime), .store(store), .packetFlags(packetFlags), .specRevision(specRevision),
    .packetDone(packetDone));

  sbcp_store_model mem_side (.core_clk(core_clk), .store(store));

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  // Counts done pulses; registered pulse is seen at exactly one edge
  always @(posedge core_clk)
    if (packetDone === 1'b1)
      doneCount++;

  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; request held until ack is sampled, read data taken at that edge
  task automatic wbAcc(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, dat};
    // No latency assumed while waiting; only the watchdog ends a hang
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    check(n, 2);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wbAcc

  function automatic logic [7:0] dByte(input int k, input int i);
    return 8'(i * 7 + k + 8'h11);
  endfunction : dByte

  // Big-endian packing, bytes past the length are zero fill
  function automatic logic [31:0] expWord(input int k, input int n, input int j);
    logic [31:0] w;
    w = 32'h0;
    for (int b = 0; b < 4; b++)
      if (4 * j + b < n)
        w[31 - 8 * b -: 8] = dByte(k, 4 * j + b);
    return w;
  endfunction : expWord

  // Bytes go back to back; a zero-length transfer is one empty beat
  task automatic sendXfer(input int k, input int n, input logic [7:0] st, input logic [3:0] sp);
    @(negedge core_clk);
    for (int w = 0; w < 50 && capReady !== 1'b1; w++)
      @(negedge core_clk);
    @(posedge core_clk);
    for (int i = 0; i < (n > 0 ? n : 1); i++)
    begin
      cap <= '{1'b1, dByte(k, i), (i == n - 1) || (n == 0), n == 0, st, sp};
      @(posedge core_clk);
    end
    cap <= '0;
    @(posedge core_clk);
    for (int w = 0; w < 50 && capReady !== 1'b1; w++)
      @(posedge core_clk);
  endtask : sendXfer

  task automatic checkXfer(input int k, input int n, input logic [7:0] st, input logic [3:0] sp,
                           input logic [1:0] ovr, input logic drop, input logic phys);
    logic [63:0] t;
    t = absOn ? absTime : (phys ? {relTime[47:32], 16'h0000, relTime[31:0]} : {16'h0000, relTime});
    check(mem_side.mem[base], t[31:0]);
    check(mem_side.mem[base + 1], t[63:32]);
    if (phys)
      check(mem_side.mem[base + 2], {st, sp, ovr, drop, 1'b0, 16'(n)});
    for (int j = 0; j < (n + 3) / 4; j++)
      check(mem_side.mem[base + 2 + phys + j], expWord(k, n, j));
    base = base + 16'(2 + phys + (n + 3) / 4);
  endtask : checkXfer

  task automatic closePkt(input logic [31:0] ctrl, input logic [31:0] cw);
    int d;
    d = doneCount;
    wbAcc(1'b1, `SBCP_OFF_CTRL, ctrl | 32'h4, 4'hF);
    for (int w = 0; w < 50 && doneCount == d; w++)
      @(negedge core_clk);
    check(doneCount, d + 1);
    check(mem_side.mem[0], cw);
    wbAcc(1'b0, `SBCP_OFF_WORDS, 32'h0, 4'hF);
    check(rd, 32'(base));
    base = 16'h0001;
  endtask : closePkt

  // Hang guard: the whole sequence needs about 8500 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    check(32'(capReady), 32'h0);
    check(32'(specRevision), 32'(`SBCP_SPEC_REV));
    wbAcc(1'b1, `SBCP_OFF_SPECREV, 32'h5C, 4'hF);
    wbAcc(1'b0, `SBCP_OFF_SPECREV, 32'h0, 4'hF);
    check(rd, 32'h5C);
    check(32'(specRevision), 32'h5C);
    // Writes without byte lane 0 and unmapped places are ignored
    wbAcc(1'b1, `SBCP_OFF_FLAGS, 32'h40, 4'hE);
    wbAcc(1'b0, `SBCP_OFF_FLAGS, 32'h0, 4'hF);
    check(rd, 32'h0);
    wbAcc(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    wbAcc(1'b0, 8'h40, 32'h0, 4'hF);
    check(rd, 32'h0);
    // Physical format: every speed code, lengths 1 to 9 for all fill cases
    wbAcc(1'b1, `SBCP_OFF_CTRL, 32'h3, 4'hF);
    wbAcc(1'b0, `SBCP_OFF_CTRL, 32'h0, 4'hF);
    check(rd, 32'h3);
    for (int s = 0; s < 9; s++)
    begin
      relTime <= 48'h1234_5678_9A00 + 48'(s);
      sendXfer(s, s + 1, 8'hA0 + 8'(s), SPD[s]);
      checkXfer(s, s + 1, 8'hA0 + 8'(s), SPD[s], 2'b00, 1'b0, 1'b1);
    end
    // Lost messages flag the next transfer only; zero length carries status alone
    @(posedge core_clk);
    capDrop <= 1'b1;
    @(posedge core_clk);
    capDrop <= 1'b0;
    wbAcc(1'b0, `SBCP_OFF_STATUS, 32'h0, 4'hF);
    check(32'(rd[31:16]), 32'h9);
    check(32'(rd[10:8]), 32'h5);
    sendXfer(0, 0, 8'h77, 4'h4);
    checkXfer(0, 0, 8'h77, 4'h4, 2'b00, 1'b1, 1'b1);
    sendXfer(1, 2, 8'h33, 4'h2);
    checkXfer(1, 2, 8'h33, 4'h2, 2'b00, 1'b0, 1'b1);
    // Overrun episode: two overlong transfers, then a correct one
    sendXfer(0, 4121, 8'h01, 4'h1);
    checkXfer(0, 4120, 8'h01, 4'h1, 2'b01, 1'b0, 1'b1);
    sendXfer(2, 4121, 8'h02, 4'h1);
    checkXfer(2, 4120, 8'h02, 4'h1, 2'b11, 1'b0, 1'b1);
    sendXfer(3, 3, 8'h03, 4'h1);
    checkXfer(3, 3, 8'h03, 4'h1, 2'b10, 1'b0, 1'b1);
    closePkt(32'h3, 32'h0000_000E);
    // Transaction format: relative stamp, then absolute stamp
    wbAcc(1'b1, `SBCP_OFF_CTRL, 32'h1, 4'hF);
    sendXfer(3, 6, 8'h00, 4'h0);
    checkXfer(3, 6, 8'h00, 4'h0, 2'b00, 1'b0, 1'b0);
    absTime <= 64'hFEDC_BA98_7654_3210;
    wbAcc(1'b1, `SBCP_OFF_FLAGS, 32'h40, 4'hF);
    check(32'(packetFlags), 32'h40);
    absOn = 1'b1;
    sendXfer(4, 13, 8'h00, 4'h0);
    checkXfer(4, 13, 8'h00, 4'h0, 2'b00, 1'b0, 1'b0);
    closePkt(32'h1, 32'h4000_0002);
    end_sim();
  end
endmodule : sbcp_packetizer_bench
